// ### tcfp_defines.svh
`ifndef TCFP_DEFINES_SVH
`define TCFP_DEFINES_SVH

// ==========================================================================
// Counter limits
`define TCFP_BOTTOM 16'h0000
`define TCFP_MAX 16'hFFFF
`define TCFP_TOP_8BIT 16'h00FF
`define TCFP_TOP_9BIT 16'h01FF
`define TCFP_TOP_10BIT 16'h03FF

// ==========================================================================
// Waveform mode codes
`define TCFP_WGM_NORMAL 4'h0
`define TCFP_WGM_FPWM8 4'h5
`define TCFP_WGM_FPWM9 4'h6
`define TCFP_WGM_FPWM10 4'h7
`define TCFP_WGM_CTC_OCA 4'h4
`define TCFP_WGM_CTC_ICR 4'hC
`define TCFP_WGM_FPWM_ICR 4'hE
`define TCFP_WGM_FPWM_OCA 4'hF

// ==========================================================================
// Reset values
`define TCFP_RST_COUNT 16'h0000
`define TCFP_RST_COMPARE 16'h0000
`define TCFP_RST_CAPTURE 16'h0000

`endif

// ### tcfp_pkg.sv
`default_nettype none

package tcfp_pkg;

  typedef enum logic [1:0] {
    TCFP_COM_OFF = 2'h0,
    TCFP_COM_TOGGLE = 2'h1,
    TCFP_COM_NONINV = 2'h2,
    TCFP_COM_INV = 2'h3
  } tcfp_com_t;

  typedef enum logic [1:0] {
    TCFP_KIND_NORMAL = 2'h0,
    TCFP_KIND_CTC = 2'h1,
    TCFP_KIND_FAST = 2'h3,
    TCFP_KIND_OTHER = 2'h2
  } tcfp_kind_t;

endpackage

`default_nettype wire

// ### tcfp_compare_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcfp_defines.svh"

module tcfp_compare_unit (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [15:0] count_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic [15:0] res_mask_i,
  input wire logic buffered_i,
  input wire logic update_i,
  input wire logic flag_set_i,
  input wire logic flag_clr_i,
  output logic [15:0] active_o,
  output logic match_o,
  output logic flag_o
);

  logic [15:0] buffer_ff;
  logic [15:0] active_ff;
  logic flag_ff;
  logic [15:0] nxt_buffer;
  logic [15:0] nxt_active;
  logic nxt_flag;

  // ========================================================================
  // Buffer, active compare and match flag
  always_comb begin
    nxt_buffer = buffer_ff;
    nxt_active = active_ff;
    if (wr_en_i) begin
      nxt_buffer = wr_data_i & res_mask_i;
    end
    if (!buffered_i) begin
      nxt_active = nxt_buffer;
    end else if (update_i) begin
      nxt_active = buffer_ff;
    end
    // A hardware set wins over a clear landing in the same cycle.
    nxt_flag = flag_ff;
    if (flag_clr_i) begin
      nxt_flag = 1'b0;
    end
    if (flag_set_i) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      buffer_ff <= `TCFP_RST_COMPARE;
      active_ff <= `TCFP_RST_COMPARE;
      flag_ff <= 1'b0;
    end else begin
      buffer_ff <= nxt_buffer;
      active_ff <= nxt_active;
      flag_ff <= nxt_flag;
    end
  end

  assign match_o = (count_i == active_ff);
  assign active_o = active_ff;
  assign flag_o = flag_ff;

endmodule // tcfp_compare_unit

`default_nettype wire

// ### tcfp_wave_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcfp_defines.svh"

module tcfp_wave_gen (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [1:0] mode_i,
  input wire logic is_fast_i,
  input wire logic match_i,
  input wire logic at_top_i,
  input wire logic at_bottom_i,
  output logic wave_o
);

  logic wave_ff;
  logic nxt_wave;

  // ========================================================================
  // Output waveform
  always_comb begin
    nxt_wave = wave_ff;
    case (tcfp_pkg::tcfp_com_t'(mode_i))
      tcfp_pkg::TCFP_COM_OFF: nxt_wave = 1'b0;
      tcfp_pkg::TCFP_COM_TOGGLE: begin
        if (match_i) begin
          nxt_wave = ~wave_ff;
        end
      end
      tcfp_pkg::TCFP_COM_NONINV: begin
        if (!is_fast_i) begin
          if (match_i) begin
            nxt_wave = 1'b0;
          end
        end else if (match_i && !at_top_i) begin
          // A compare equal to TOP gives a constant high output.
          nxt_wave = 1'b0;
        end else if (at_bottom_i) begin
          nxt_wave = 1'b1;
        end
      end
      tcfp_pkg::TCFP_COM_INV: begin
        if (!is_fast_i) begin
          if (match_i) begin
            nxt_wave = 1'b1;
          end
        end else if (match_i && !at_top_i) begin
          nxt_wave = 1'b1;
        end else if (at_bottom_i) begin
          nxt_wave = 1'b0;
        end
      end
      default: nxt_wave = wave_ff;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wave_ff <= 1'b0;
    end else begin
      wave_ff <= nxt_wave;
    end
  end

  assign wave_o = wave_ff;

endmodule // tcfp_wave_gen

`default_nettype wire

// ### tcfp_timer.sv
// Summary of operation
// - Each compare value is checked against the 16-bit count every cycle.
// - A match sets its flag one timer cycle after the match.
// - Enabled flag requests interrupt; interrupt acknowledge clears it.
// - Writing one to a flag clears it; zero leaves it.
// - Outputs follow match, waveform mode, output mode, TOP and BOTTOM.
// - Compare A may set TOP, fixing resolution and period.
// - Compare values double buffered in PWM modes, immediate otherwise.
// - Buffered compare values load into active registers at TOP or BOTTOM.
// - Fast PWM TOP is fixed 8/9/10 bits, capture or compare A.
// - Modes 5, 6, 7 count to 0x00FF, 0x01FF, 0x03FF.
// - Mode 14 takes TOP from capture, mode 15 from compare A.
// - At TOP the counter clears to zero the next cycle.
// - Overflow flag sets when the counter reaches TOP in fast PWM, 0xFFFF otherwise.
// - In fast PWM, compare A or capture flag sets with overflow when defining TOP.
// - Fixed TOP modes store zeros above resolution on compare writes.
// - Capture TOP unbuffered; missed TOP runs to 0xFFFF and wraps.
`timescale 1ns/1ps
`default_nettype none
`include "tcfp_defines.svh"

module tcfp_timer (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [3:0] waveform_mode_sel_i,
  input wire logic [1:0] compare_output_mode_a_i,
  input wire logic [1:0] compare_output_mode_b_i,
  input wire logic [15:0] wr_data_i,
  input wire logic compare_value_a_wr_i,
  input wire logic compare_value_b_wr_i,
  input wire logic capture_value_reg_wr_i,
  input wire logic timer_count16_wr_i,
  input wire logic compare_irq_enable_a_i,
  input wire logic compare_irq_enable_b_i,
  input wire logic overflow_irq_enable_i,
  input wire logic capture_irq_enable_i,
  input wire logic [3:0] flag_clr_i,
  input wire logic [3:0] irq_ack_i,
  input wire logic capture_event_i,
  output logic [15:0] timer_count16_o,
  output logic [15:0] compare_value_a_o,
  output logic [15:0] compare_value_b_o,
  output logic [15:0] capture_value_reg_o,
  output logic compare_match_flag_a_o,
  output logic compare_match_flag_b_o,
  output logic overflow_flag_o,
  output logic capture_flag_o,
  output logic [3:0] irq_req_o,
  output logic wave_output_a_o,
  output logic wave_output_b_o
);

  // ========================================================================
  // Mode decoding
  function automatic tcfp_pkg::tcfp_kind_t mode_kind(input logic [3:0] m);
    case (m)
      `TCFP_WGM_NORMAL: mode_kind = tcfp_pkg::TCFP_KIND_NORMAL;
      `TCFP_WGM_CTC_OCA, `TCFP_WGM_CTC_ICR: mode_kind = tcfp_pkg::TCFP_KIND_CTC;
      `TCFP_WGM_FPWM8, `TCFP_WGM_FPWM9, `TCFP_WGM_FPWM10,
      `TCFP_WGM_FPWM_ICR, `TCFP_WGM_FPWM_OCA:
        mode_kind = tcfp_pkg::TCFP_KIND_FAST;
      default: mode_kind = tcfp_pkg::TCFP_KIND_OTHER;
    endcase
  endfunction

  function automatic logic [15:0] fixed_mask(input logic [3:0] m);
    case (m)
      `TCFP_WGM_FPWM8: fixed_mask = `TCFP_TOP_8BIT;
      `TCFP_WGM_FPWM9: fixed_mask = `TCFP_TOP_9BIT;
      `TCFP_WGM_FPWM10: fixed_mask = `TCFP_TOP_10BIT;
      default: fixed_mask = `TCFP_MAX;
    endcase
  endfunction

  tcfp_pkg::tcfp_kind_t kind;
  logic is_fast;
  logic buffered;
  logic [15:0] res_mask;
  logic [15:0] top_value;
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic [15:0] capture_ff;
  logic match_a;
  logic match_b;
  logic at_top;
  logic at_bottom;
  logic top_from_a;
  logic top_from_icr;

  assign kind = mode_kind(waveform_mode_sel_i);
  assign is_fast = (kind == tcfp_pkg::TCFP_KIND_FAST);
  // Any mode other than normal and CLEAR_ON_COMPARE_MODE is a PWM mode and buffers compares.
  assign buffered = (kind != tcfp_pkg::TCFP_KIND_NORMAL) &&
                    (kind != tcfp_pkg::TCFP_KIND_CTC);
  assign res_mask = fixed_mask(waveform_mode_sel_i);
  assign top_from_a = (waveform_mode_sel_i == `TCFP_WGM_FPWM_OCA) ||
                      (waveform_mode_sel_i == `TCFP_WGM_CTC_OCA);
  assign top_from_icr = (waveform_mode_sel_i == `TCFP_WGM_FPWM_ICR) ||
                        (waveform_mode_sel_i == `TCFP_WGM_CTC_ICR);

  // ========================================================================
  // TOP selection
  always_comb begin
    if (top_from_a) begin
      top_value = cmp_a;
    end else if (top_from_icr) begin
      top_value = capture_ff;
    end else begin
      top_value = res_mask;
    end
  end

  // ========================================================================
  // Counter, overflow and capture state
  logic [15:0] count_ff;
  logic ovf_ff;
  logic icf_ff;
  logic top_hit;
  logic [15:0] nxt_count;
  logic [15:0] nxt_capture;
  logic nxt_ovf;
  logic nxt_icf;

  assign at_top = (count_ff == top_value) && (kind != tcfp_pkg::TCFP_KIND_NORMAL);
  assign at_bottom = (count_ff == `TCFP_BOTTOM);

  always_comb begin
    nxt_count = count_ff + 16'h0001;
    // Overflow past MAX simply wraps, which is how a missed TOP recovers.
    if (at_top) begin
      nxt_count = `TCFP_BOTTOM;
    end
    if (timer_count16_wr_i) begin
      nxt_count = wr_data_i;
    end
    nxt_capture = capture_ff;
    if (capture_value_reg_wr_i) begin
      nxt_capture = wr_data_i;
    end else if (capture_event_i && !top_from_icr) begin
      nxt_capture = count_ff;
    end
    // The flag flops give the one-cycle delay, like the compare flags.
    top_hit = is_fast ? at_top : (count_ff == `TCFP_MAX);
    nxt_ovf = ovf_ff;
    if (flag_clr_i[2] || irq_ack_i[2]) begin
      nxt_ovf = 1'b0;
    end
    if (top_hit) begin
      nxt_ovf = 1'b1;
    end
    nxt_icf = icf_ff;
    if (flag_clr_i[3] || irq_ack_i[3]) begin
      nxt_icf = 1'b0;
    end
    if ((is_fast && top_from_icr && top_hit) ||
        (capture_event_i && !top_from_icr)) begin
      nxt_icf = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      count_ff <= `TCFP_RST_COUNT;
      capture_ff <= `TCFP_RST_CAPTURE;
      ovf_ff <= 1'b0;
      icf_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      capture_ff <= nxt_capture;
      ovf_ff <= nxt_ovf;
      icf_ff <= nxt_icf;
    end
  end

  // ========================================================================
  // Compare units
  // Fast PWM loads at TOP so the new value applies from the next period.
  tcfp_compare_unit u_cmp_a (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .count_i(count_ff),
    .wr_data_i(wr_data_i),
    .wr_en_i(compare_value_a_wr_i),
    .res_mask_i(res_mask),
    .buffered_i(buffered),
    .update_i(is_fast ? at_top : at_bottom),
    .flag_set_i(match_a),
    .flag_clr_i(flag_clr_i[0] || irq_ack_i[0]),
    .active_o(cmp_a),
    .match_o(match_a),
    .flag_o(compare_match_flag_a_o)
  );

  tcfp_compare_unit u_cmp_b (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .count_i(count_ff),
    .wr_data_i(wr_data_i),
    .wr_en_i(compare_value_b_wr_i),
    .res_mask_i(res_mask),
    .buffered_i(buffered),
    .update_i(is_fast ? at_top : at_bottom),
    .flag_set_i(match_b),
    .flag_clr_i(flag_clr_i[1] || irq_ack_i[1]),
    .active_o(cmp_b),
    .match_o(match_b),
    .flag_o(compare_match_flag_b_o)
  );

  // ========================================================================
  // Waveform outputs
  tcfp_wave_gen u_wave_a (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .mode_i(compare_output_mode_a_i),
    .is_fast_i(is_fast),
    .match_i(match_a),
    .at_top_i(at_top),
    .at_bottom_i(at_bottom),
    .wave_o(wave_output_a_o)
  );

  tcfp_wave_gen u_wave_b (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .mode_i(compare_output_mode_b_i),
    .is_fast_i(is_fast),
    .match_i(match_b),
    .at_top_i(at_top),
    .at_bottom_i(at_bottom),
    .wave_o(wave_output_b_o)
  );

  // ========================================================================
  // Status and interrupt requests
  assign timer_count16_o = count_ff;
  assign compare_value_a_o = cmp_a;
  assign compare_value_b_o = cmp_b;
  assign capture_value_reg_o = capture_ff;
  assign overflow_flag_o = ovf_ff;
  assign capture_flag_o = icf_ff;
  assign irq_req_o = {capture_irq_enable_i & icf_ff,
                      overflow_irq_enable_i & ovf_ff,
                      compare_irq_enable_b_i & compare_match_flag_b_o,
                      compare_irq_enable_a_i & compare_match_flag_a_o};

endmodule // tcfp_timer

`default_nettype wire

// ### tcfp_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none

module tcfp_timer_chk (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [3:0] waveform_mode_sel_i,
  input wire logic [1:0] compare_output_mode_a_i,
  input wire logic [15:0] wr_data_i,
  input wire logic compare_value_a_wr_i,
  input wire logic timer_count16_wr_i,
  input wire logic compare_irq_enable_a_i,
  input wire logic [3:0] flag_clr_i,
  input wire logic [3:0] irq_ack_i,
  input wire logic [15:0] timer_count16_o,
  input wire logic [15:0] compare_value_a_o,
  input wire logic compare_match_flag_a_o,
  input wire logic overflow_flag_o,
  input wire logic [3:0] irq_req_o,
  input wire logic wave_output_a_o
);
  // ==========================================================
  // Helper decode.
  logic [15:0] top, cnt, cva;
  logic fast, hit, at_top, fa, m5;
  assign cnt = timer_count16_o;
  assign cva = compare_value_a_o;
  assign fa = compare_match_flag_a_o;
  assign hit = cnt == cva;
  assign m5 = waveform_mode_sel_i == 4'h5 && compare_output_mode_a_i == 2'h2;
  assign fast = waveform_mode_sel_i inside {4'h5, 4'h6, 4'h7, 4'hF};
  assign at_top = fast && cnt == top;
  always_comb begin
    case (waveform_mode_sel_i)
      4'h5: top = 16'h00FF;
      4'h6: top = 16'h01FF;
      4'h7: top = 16'h03FF;
      4'hF: top = cva;
      default: top = 16'hFFFF;
    endcase
  end

  // ==========================================================
  // Assertions.
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence s_top;
    at_top && !timer_count16_wr_i;
  endsequence
  sequence s_wrapped;
    cnt == 16'h0000 && overflow_flag_o;
  endsequence
  a_top_wrap: assert property (s_top |=> s_wrapped)
    else $error("no wrap after top");
  a_flag_next: assert property (hit |=> fa)
    else $error("match flag not set");
  a_flag_cause: assert property ($rose(fa) |-> $past(hit))
    else $error("flag set without match");
  a_clear_one: assert property (fa && flag_clr_i[0] && !hit |=> !fa)
    else $error("flag not cleared by one");
  a_flag_keep: assert property (
    fa && !flag_clr_i[0] && !irq_ack_i[0] |=> fa)
    else $error("flag lost");
  a_ack_clear: assert property (fa && irq_ack_i[0] && !hit |=> !fa)
    else $error("flag kept after ack");
  a_irq_req: assert property (
    irq_req_o[0] == (compare_irq_enable_a_i && fa))
    else $error("irq request wrong");
  a_count_step: assert property (
    fast && !at_top && !timer_count16_wr_i |=> cnt == $past(cnt) + 16'h0001)
    else $error("count step wrong");
  a_buf_hold: assert property (fast && !at_top |=> $stable(cva))
    else $error("compare changed off top");
  a_imm_write: assert property (
    waveform_mode_sel_i == 4'h0 && compare_value_a_wr_i
    |=> cva == $past(wr_data_i))
    else $error("compare write not immediate");
  a_top_flags: assert property (
    waveform_mode_sel_i == 4'hF && hit |=> overflow_flag_o && fa)
    else $error("top flags not together");
  a_wave_clear: assert property (
    m5 && hit && cnt != 16'h0000 && cnt != 16'h00FF |=> !wave_output_a_o)
    else $error("wave not cleared on match");
  a_wave_set: assert property (
    m5 && cnt == 16'h0000 && cva != 16'h0000 |=> wave_output_a_o)
    else $error("wave not set at bottom");
endmodule // tcfp_timer_chk

`default_nettype wire

// ### tcfp_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tcfp_timer_tb;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] mode = 4'h0, ien = 4'h0, clr = 4'h0, ack = 4'h0, stb = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] cnt, cva, cvb, cap;
  logic fa, fb, fo, fc, wa, wb;
  logic [3:0] irq;
  int err_total = 0;
  int n_compared = 0;

  always #20 clock_i = ~clock_i;

  tcfp_timer dut (
    .clock_i, .srst_i, .waveform_mode_sel_i(mode),
    .compare_output_mode_a_i(2'h2), .compare_output_mode_b_i(2'h3),
    .wr_data_i(wd), .compare_value_a_wr_i(stb[0]),
    .compare_value_b_wr_i(stb[1]), .capture_value_reg_wr_i(stb[2]),
    .timer_count16_wr_i(stb[3]), .compare_irq_enable_a_i(ien[0]),
    .compare_irq_enable_b_i(ien[1]), .overflow_irq_enable_i(ien[2]),
    .capture_irq_enable_i(ien[3]), .flag_clr_i(clr), .irq_ack_i(ack),
    .capture_event_i(1'b0), .timer_count16_o(cnt),
    .compare_value_a_o(cva), .compare_value_b_o(cvb),
    .capture_value_reg_o(cap), .compare_match_flag_a_o(fa),
    .compare_match_flag_b_o(fb), .overflow_flag_o(fo),
    .capture_flag_o(fc), .irq_req_o(irq), .wave_output_a_o(wa),
    .wave_output_b_o(wb)
  );

  // ==========================================================
  // Shared tasks.
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic chkb(input logic s, input logic e);
    chk({15'h0000, s}, {15'h0000, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Outputs are read at the falling edge so flop updates have landed.
  task automatic look;
    @(negedge clock_i);
  endtask

  // Strobes stand one cycle; the design takes them at the second edge.
  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    @(posedge clock_i);
    stb <= s;
    wd <= d;
    @(posedge clock_i);
    stb <= 4'h0;
  endtask

  task automatic hit(input logic [3:0] m, input logic a);
    @(posedge clock_i);
    if (a)
      ack <= m;
    else
      clr <= m;
    @(posedge clock_i);
    ack <= 4'h0;
    clr <= 4'h0;
  endtask

  // ==========================================================
  // Scenarios.
  task automatic t_norm;
    wr(4'h2, 16'h0020);
    wr(4'h1, 16'h0050);
    look;
    chk(cva, 16'h0050);
    chk(cvb, 16'h0020);
    hit(4'hF, 1'b0);
    wr(4'h8, 16'h004E);
    cyc(2);
    look;
    chkb(fa, 1'b0);
    cyc(1);
    look;
    chkb(fa, 1'b1);
    chk({12'h000, irq}, 16'h0000);
    @(posedge clock_i);
    ien <= 4'hF;
    look;
    chk({12'h000, irq}, 16'h0001);
    hit(4'h1, 1'b1);
    look;
    chkb(fa, 1'b0);
    wr(4'h8, 16'h0050);
    hit(4'h2, 1'b0);
    look;
    chkb(fa, 1'b1);
    hit(4'h1, 1'b0);
    look;
    chkb(fa, 1'b0);
  endtask

  task automatic t_fast8;
    @(posedge clock_i);
    mode <= 4'h5;
    wr(4'h1, 16'hFF10);
    look;
    chk(cva, 16'h0050);
    hit(4'hF, 1'b0);
    wr(4'h8, 16'h00FD);
    cyc(2);
    look;
    chk(cnt, 16'h00FF);
    chkb(fo, 1'b0);
    cyc(1);
    look;
    chk(cnt, 16'h0000);
    chkb(fo, 1'b1);
    chk(cva, 16'h0010);
    cyc(1);
    look;
    chkb(wa, 1'b1);
    chkb(wb, 1'b0);
    cyc(16);
    look;
    chkb(wa, 1'b0);
    chkb(fb, 1'b0);
    cyc(16);
    look;
    chkb(wb, 1'b1);
    chkb(fb, 1'b1);
  endtask

  task automatic t_fixed;
    logic [15:0] tops [3] = '{16'h00FF, 16'h01FF, 16'h03FF};
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_i);
      mode <= 4'h5 + 4'(i);
      wr(4'h8, tops[i] - 16'h0001);
      cyc(1);
      look;
      chk(cnt, tops[i]);
      cyc(1);
      look;
      chk(cnt, 16'h0000);
    end
  endtask

  task automatic t_cap;
    @(posedge clock_i);
    mode <= 4'hE;
    wr(4'h4, 16'h0020);
    look;
    chk(cap, 16'h0020);
    hit(4'hF, 1'b0);
    wr(4'h8, 16'h001F);
    cyc(2);
    look;
    chk(cnt, 16'h0000);
    chkb(fo, 1'b1);
    chkb(fc, 1'b1);
    wr(4'h8, 16'h0030);
    cyc(4);
    look;
    chk(cnt, 16'h0034);
    wr(4'h8, 16'hFFFF);
    cyc(1);
    look;
    chk(cnt, 16'h0000);
  endtask

  task automatic t_topa;
    @(posedge clock_i);
    mode <= 4'h0;
    // TOP of 0x30 stays above compare B at 0x20.
    wr(4'h1, 16'h0030);
    @(posedge clock_i);
    mode <= 4'hF;
    hit(4'hF, 1'b0);
    wr(4'h8, 16'h002E);
    cyc(3);
    look;
    chk(cnt, 16'h0000);
    chkb(fo, 1'b1);
    chkb(fa, 1'b1);
  endtask

  task automatic final_report;
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    srst_i <= 1'b0;
    t_norm;
    t_fast8;
    t_fixed;
    t_cap;
    t_topa;
    final_report;
  end

  // The scenarios need about 130 cycles; this leaves ample margin.
  initial begin
    repeat (3000) @(posedge clock_i);
    err_total++;
    final_report;
  end
endmodule // tcfp_timer_tb

bind tcfp_timer tcfp_timer_chk chk (
  .clock_i, .srst_i, .waveform_mode_sel_i, .compare_output_mode_a_i,
  .wr_data_i, .compare_value_a_wr_i, .timer_count16_wr_i,
  .compare_irq_enable_a_i, .flag_clr_i, .irq_ack_i, .timer_count16_o,
  .compare_value_a_o, .compare_match_flag_a_o, .overflow_flag_o,
  .irq_req_o, .wave_output_a_o
);

`default_nettype wire
